// *** rtl/uebc_pkg.sv ***
// Package: register map, field positions and timing for the endpoint bank controller
package uebc_pkg;
	localparam logic [7:0] A_DEV_CTRL  = 8'h00;
	localparam logic [7:0] A_DEV_FLAGS = 8'h04;
	localparam logic [7:0] A_DEV_EN    = 8'h08;
	localparam logic [7:0] A_FRAME_ERR = 8'h0C;
	localparam logic [7:0] A_EP_CFG    = 8'h10;
	localparam logic [7:0] A_EP_FLAGS  = 8'h14;
	localparam logic [7:0] A_EP_EN     = 8'h18;
	localparam logic [7:0] A_EP_DATA   = 8'h1C;
	localparam logic [7:0] A_EP_COUNT  = 8'h20;
	// usb_device_control fields
	localparam int CTL_DETACH = 0;
	localparam int CTL_WAKEUP = 1;
	localparam int CTL_CPU_RST = 2;
	localparam logic [7:0] DEV_CTRL_RST = 8'h01;
	// usb_device_interrupt_flags fields
	localparam int DEV_SUSP  = 0;
	localparam int DEV_SOF   = 2;
	localparam int DEV_UPRSM = 6;
	localparam logic [7:0] DEV_MASK = 8'h45;
	localparam int FNC_BIT = 4;
	// Endpoint configuration
	localparam int CFG_DIR_IN = 0;
	localparam int CFG_DUAL   = 1;
	localparam int CFG_ISO    = 2;
	// Endpoint flag and control fields
	localparam int EPF_IN    = 0;
	localparam int EPF_STALL = 1;
	localparam int EPF_OUT   = 2;
	localparam int EPF_NAKO  = 3;
	localparam int EPF_NAKI  = 4;
	localparam int EPF_OVF   = 5;
	localparam int EPF_UNDER = 6;
	localparam int EPS_ACCESS = 7;
	localparam int EPS_BANK   = 8;
	localparam int EPS_KILL   = 9;
	// Timing
	localparam int CLK_MHZ = 250;
	localparam int SUSPEND_IDLE_US = 3000;
	localparam int SUSPEND_CYCLES = SUSPEND_IDLE_US * CLK_MHZ;
	localparam int BANK_BYTES = 64;
endpackage : uebc_pkg

// *** rtl/uebc_top.sv ***
// Endpoint bank controller with device control, APB registers and checks
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ns
module uebc_top #(
	parameter int BANK_BYTES  = uebc_pkg::BANK_BYTES,
	parameter int IDLE_CYCLES = uebc_pkg::SUSPEND_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        usb_enable,
	input  wire logic        bus_idle,
	input  wire logic        bus_reset,
	input  wire logic        sof_rx,
	input  wire logic        sof_crc_err,
	input  wire logic        in_token,
	input  wire logic        rx_start,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_end,
	input  wire logic        rx_crc_err,
	input  wire logic        resume_done,
	output logic             tx_valid,
	output logic [7:0]       tx_byte,
	output logic             tx_last,
	output logic             out_ack,
	output logic             tx_nak,
	output logic             resume_start,
	output logic             cpu_reset,
	output logic             pullup_en,
	output logic             endpoint_irq,
	output logic             device_irq
);
	localparam int CW = $clog2(BANK_BYTES + 1);
	localparam int AW = $clog2(BANK_BYTES);
	localparam int IW = $clog2(IDLE_CYCLES + 1);
	localparam logic [CW-1:0] BANK = CW'(BANK_BYTES);
	localparam logic [IW-1:0] IDLE_END = IW'(IDLE_CYCLES - 1);

	typedef struct packed {
		logic [1:0]         full;
		logic [1:0][CW-1:0] cnt;
		logic               cpu_bank;
		logic               usb_bank;
		logic [CW-1:0]      cpu_ptr;
		logic               avail;
		logic               rx_ok;
		logic               rx_ovf;
		logic [CW-1:0]      rx_cnt;
		logic               sending;
		logic [CW-1:0]      tx_idx;
		logic [6:0]         epf;
		logic [6:0]         epe;
		logic [2:0]         cfg;
		logic [7:0]         ctrl;
		logic [7:0]         devf;
		logic [7:0]         deve;
		logic               frame_crc_error;
		logic [IW-1:0]      idle_cnt;
		logic               pready;
		logic [31:0]        prdata;
		logic               pslverr;
		logic               tx_valid;
		logic [7:0]         tx_byte;
		logic               tx_last;
		logic               out_ack;
		logic               tx_nak;
		logic               resume_start;
		logic               cpu_reset;
		logic               pullup_en;
		logic               endpoint_irq;
		logic               device_irq;
	} uebc_state_t;

	uebc_state_t s;
	uebc_state_t n;
	logic [7:0]  mem [2][BANK_BYTES];
	logic        mem_we;
	logic        mem_bank;
	logic [AW-1:0] mem_addr;
	logic [7:0]  mem_wdata;
	logic        switched;
	logic        acc;
	logic        in_mode;
	logic        dual;
	logic        iso;
	logic        prev_bank;
	logic        access_ok;

	assign acc       = psel && penable && s.pready;
	assign in_mode   = s.cfg[uebc_pkg::CFG_DIR_IN];
	assign dual      = s.cfg[uebc_pkg::CFG_DUAL];
	assign iso       = s.cfg[uebc_pkg::CFG_ISO];
	assign prev_bank = s.cpu_bank ^ dual;
	assign access_ok = s.avail && (in_mode ? (s.cpu_ptr < BANK)
		: (s.cpu_ptr < s.cnt[s.cpu_bank]));

	always_comb begin
		n = s;
		n.out_ack = 1'b0;
		n.tx_nak = 1'b0;
		n.resume_start = 1'b0;
		n.cpu_reset = 1'b0;
		n.tx_valid = 1'b0;
		n.tx_last = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		mem_we = 1'b0;
		mem_bank = s.usb_bank;
		mem_addr = s.rx_cnt[AW-1:0];
		mem_wdata = rx_byte;
		switched = 1'b0;
		// Software side: clears are applied first so that hardware events below win
		if (acc && pwrite) begin
			case (paddr[7:0])
				uebc_pkg::A_DEV_CTRL: begin
					n.ctrl[uebc_pkg::CTL_CPU_RST] = pwdata[uebc_pkg::CTL_CPU_RST];
					n.ctrl[uebc_pkg::CTL_DETACH] = pwdata[uebc_pkg::CTL_DETACH];
					n.resume_start = pwdata[uebc_pkg::CTL_WAKEUP];
				end
				uebc_pkg::A_DEV_FLAGS: n.devf = s.devf & pwdata[7:0];
				uebc_pkg::A_DEV_EN: n.deve = pwdata[7:0] & uebc_pkg::DEV_MASK;
				uebc_pkg::A_FRAME_ERR: n.frame_crc_error = s.frame_crc_error & pwdata[uebc_pkg::FNC_BIT];
				uebc_pkg::A_EP_CFG: n.cfg = pwdata[2:0];
				uebc_pkg::A_EP_EN: n.epe = pwdata[6:0];
				uebc_pkg::A_EP_FLAGS: begin
					n.epf = s.epf & pwdata[6:0];
					if (s.avail && !pwdata[uebc_pkg::EPS_BANK]) begin
						n.full[s.cpu_bank] = in_mode;
						if (in_mode) begin
							n.cnt[s.cpu_bank] = s.cpu_ptr;
						end
						n.cpu_bank = s.cpu_bank ^ dual;
						n.cpu_ptr = '0;
						switched = 1'b1;
					end
					// A bank already on the wire cannot be recalled
					if (in_mode && pwdata[uebc_pkg::EPS_KILL] && s.full[prev_bank]
						&& !(s.sending && prev_bank == s.usb_bank)) begin
						n.full[prev_bank] = 1'b0;
					end
				end
				uebc_pkg::A_EP_DATA: begin
					if (in_mode && s.avail && s.cpu_ptr < BANK) begin
						mem_we = 1'b1;
						mem_bank = s.cpu_bank;
						mem_addr = s.cpu_ptr[AW-1:0];
						mem_wdata = pwdata[7:0];
						n.cpu_ptr = s.cpu_ptr + 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (acc && !pwrite && paddr[7:0] == uebc_pkg::A_EP_DATA && !in_mode
			&& s.cpu_ptr < s.cnt[s.cpu_bank]) begin
			n.cpu_ptr = s.cpu_ptr + 1'b1;
		end
		// OUT packet reception
		if (rx_start) begin
			n.rx_ok = !s.full[s.usb_bank] && !in_mode;
			n.rx_cnt = '0;
			n.rx_ovf = 1'b0;
		end else if (rx_valid && s.rx_ok) begin
			if (s.rx_cnt < BANK) begin
				mem_we = 1'b1;
				n.rx_cnt = s.rx_cnt + 1'b1;
			end else begin
				n.rx_ovf = 1'b1;
			end
		end
		if (rx_end) begin
			if (s.rx_ok && !(rx_crc_err && !iso)) begin
				n.full[s.usb_bank] = 1'b1;
				n.cnt[s.usb_bank] = s.rx_cnt;
				n.usb_bank = s.usb_bank ^ dual;
				n.out_ack = 1'b1;
				if (s.rx_ovf) begin
					n.epf[uebc_pkg::EPF_OVF] = 1'b1;
				end
				if (rx_crc_err) begin
					n.epf[uebc_pkg::EPF_STALL] = 1'b1;
				end
			end else if (!s.rx_ok && !iso && !in_mode) begin
				n.tx_nak = 1'b1;
				n.epf[uebc_pkg::EPF_NAKO] = 1'b1;
			end
			// Isochronous packets with no free bank fall through unstored
			n.rx_ok = 1'b0;
		end
		// IN packet transmission
		if (in_token && in_mode && !s.sending) begin
			if (s.full[s.usb_bank]) begin
				n.sending = 1'b1;
				n.tx_idx = '0;
			end else if (iso) begin
				n.epf[uebc_pkg::EPF_UNDER] = 1'b1;
			end else begin
				n.tx_nak = 1'b1;
				n.epf[uebc_pkg::EPF_NAKI] = 1'b1;
			end
		end
		if (s.sending) begin
			n.tx_valid = s.cnt[s.usb_bank] != '0;
			n.tx_byte = mem[s.usb_bank][s.tx_idx[AW-1:0]];
			n.tx_idx = s.tx_idx + 1'b1;
			if (s.cnt[s.usb_bank] == '0 || n.tx_idx == s.cnt[s.usb_bank]) begin
				n.tx_last = 1'b1;
				n.sending = 1'b0;
				n.full[s.usb_bank] = 1'b0;
				n.usb_bank = s.usb_bank ^ dual;
			end
		end
		// Device level events
		if (sof_rx) begin
			n.devf[uebc_pkg::DEV_SOF] = 1'b1;
			if (sof_crc_err) begin
				n.frame_crc_error = 1'b1;
			end
		end
		if (bus_idle) begin
			if (s.idle_cnt < IW'(IDLE_CYCLES)) begin
				n.idle_cnt = s.idle_cnt + 1'b1;
			end
			if (s.idle_cnt == IDLE_END) begin
				n.devf[uebc_pkg::DEV_SUSP] = 1'b1;
			end
		end else begin
			n.idle_cnt = '0;
		end
		if (resume_done) begin
			n.devf[uebc_pkg::DEV_UPRSM] = 1'b1;
		end
		if (bus_reset && s.ctrl[uebc_pkg::CTL_CPU_RST]) begin
			n.cpu_reset = 1'b1;
		end
		if (!usb_enable) begin
			n.ctrl[uebc_pkg::CTL_CPU_RST] = 1'b0;
		end
		// Ready flags follow the current bank; a switch onto a ready bank counts as new
		n.avail = in_mode ? !n.full[n.cpu_bank] : n.full[n.cpu_bank];
		if (n.avail && (!s.avail || switched)) begin
			if (in_mode) begin
				n.epf[uebc_pkg::EPF_IN] = 1'b1;
			end else begin
				n.epf[uebc_pkg::EPF_OUT] = 1'b1;
			end
		end
		n.pullup_en = !n.ctrl[uebc_pkg::CTL_DETACH];
		n.endpoint_irq = |(n.epf & n.epe);
		n.device_irq = |(n.devf & n.deve);
		// One wait state keeps every read value registered
		if (psel && penable && !s.pready) begin
			n.pready = 1'b1;
			n.prdata = '0;
			case (paddr[7:0])
				uebc_pkg::A_DEV_CTRL: n.prdata = 32'(s.ctrl);
				uebc_pkg::A_DEV_FLAGS: n.prdata = 32'(s.devf);
				uebc_pkg::A_DEV_EN: n.prdata = 32'(s.deve);
				uebc_pkg::A_FRAME_ERR: n.prdata = 32'(s.frame_crc_error) << uebc_pkg::FNC_BIT;
				uebc_pkg::A_EP_CFG: n.prdata = 32'(s.cfg);
				uebc_pkg::A_EP_FLAGS: n.prdata = 32'({s.avail, access_ok, s.epf});
				uebc_pkg::A_EP_EN: n.prdata = 32'(s.epe);
				uebc_pkg::A_EP_DATA: n.prdata = 32'(mem[s.cpu_bank][s.cpu_ptr[AW-1:0]]);
				uebc_pkg::A_EP_COUNT: n.prdata = in_mode ? 32'(s.cpu_ptr)
					: 32'(s.cnt[s.cpu_bank]);
				default: n.pslverr = 1'b1;
			endcase
		end
		if (srst) begin
			n = '0;
			n.ctrl = uebc_pkg::DEV_CTRL_RST;
		end
	end

	always_ff @(posedge clk) begin
		s <= n;
	end

	// Bank storage carries no reset; the counts gate tx_valid and the read pointer, but A_EP_DATA reads return it unchecked
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[mem_bank][mem_addr] <= mem_wdata;
		end
	end

	assign pready       = s.pready;
	assign prdata       = s.prdata;
	assign pslverr      = s.pslverr;
	assign tx_valid     = s.tx_valid;
	assign tx_byte      = s.tx_byte;
	assign tx_last      = s.tx_last;
	assign out_ack      = s.out_ack;
	assign tx_nak       = s.tx_nak;
	assign resume_start = s.resume_start;
	assign cpu_reset    = s.cpu_reset;
	assign pullup_en    = s.pullup_en;
	assign endpoint_irq = s.endpoint_irq;
	assign device_irq   = s.device_irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	logic wr_ctrl;
	logic bank_free_wr;
	assign wr_ctrl = acc && pwrite && paddr[7:0] == uebc_pkg::A_DEV_CTRL;
	assign bank_free_wr = acc && pwrite && paddr[7:0] == uebc_pkg::A_EP_FLAGS
		&& s.avail && !pwdata[uebc_pkg::EPS_BANK];

	sequence wake_req_s;
		wr_ctrl && pwdata[uebc_pkg::CTL_WAKEUP];
	endsequence
	sequence wake_pulse_s;
		resume_start && !s.ctrl[uebc_pkg::CTL_WAKEUP] ##1 !resume_start;
	endsequence

	ready_flag_set_a: assert property ($rose(s.avail) |->
		s.epf[in_mode ? uebc_pkg::EPF_IN : uebc_pkg::EPF_OUT])
		else $error("ready flag missing on bank ready");
	// The irq register is loaded from the same next state as the flags and enables
	ep_irq_out_a: assert property (s.epf[uebc_pkg::EPF_OUT] && s.epe[uebc_pkg::EPF_OUT]
		|-> endpoint_irq)
		else $error("endpoint irq not raised");
	bank_advance_a: assert property (bank_free_wr && dual |=>
		s.cpu_bank != $past(s.cpu_bank) && s.cpu_ptr == '0)
		else $error("bank did not advance");
	access_ok_a: assert property (acc && !pwrite && paddr[7:0] == uebc_pkg::A_EP_DATA
		&& !in_mode && access_ok
		&& s.cpu_ptr + 1'b1 == s.cnt[s.cpu_bank] |=> !access_ok)
		else $error("access ok after last byte read");
	underflow_a: assert property (in_token && in_mode && iso && !s.sending
		&& !s.full[s.usb_bank] |=> s.epf[uebc_pkg::EPF_UNDER] && !s.sending)
		else $error("underflow flag not set");
	overflow_a: assert property (rx_end && s.rx_ok && s.rx_ovf && !rx_crc_err |=>
		s.epf[uebc_pkg::EPF_OVF] && out_ack && s.cnt[$past(s.usb_bank)] == BANK)
		else $error("overflow handling wrong");
	suspend_a: assert property (bus_idle && s.idle_cnt == IDLE_END |=>
		s.devf[uebc_pkg::DEV_SUSP])
		else $error("suspend flag late");
	wakeup_a: assert property (wake_req_s |=> wake_pulse_s)
		else $error("resume request pulse wrong");
	detach_a: assert property ($fell(srst) |-> !pullup_en
		&& s.ctrl[uebc_pkg::CTL_DETACH])
		else $error("device not detached after reset");
	cpu_reset_a: assert property (bus_reset && s.ctrl[uebc_pkg::CTL_CPU_RST] |=>
		cpu_reset ##1 !cpu_reset)
		else $error("cpu reset pulse missing");
endmodule : uebc_top

// *** verif/uebc_host.sv ***
// Host side model: OUT packets, IN tokens, bus events and resume answers
`timescale 1ns/1ns
module uebc_host (
	input  wire logic       clk,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_last,
	input  wire logic       out_ack,
	input  wire logic       tx_nak,
	input  wire logic       resume_start,
	input  wire logic       cpu_reset,
	output logic            bus_idle,
	output logic            bus_reset,
	output logic            sof_rx,
	output logic            sof_crc_err,
	output logic            in_token,
	output logic            rx_start,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	output logic            rx_end,
	output logic            rx_crc_err,
	output logic            resume_done
);
	logic [7:0] got[$];
	int         n_resume = 0;
	int         n_cpurst = 0;
	int         rs_cnt   = 0;
	initial begin
		{bus_idle, bus_reset, sof_rx, sof_crc_err, in_token, rx_start} = '0;
		{rx_valid, rx_byte, rx_end, rx_crc_err} = '0;
	end
	// Resume is answered a few cycles late, as on a real line
	always @(posedge clk) begin
		resume_done <= (rs_cnt == 1);
		rs_cnt <= (resume_start === 1'b1) ? 3 : (rs_cnt > 0 ? rs_cnt - 1 : 0);
		n_resume <= n_resume + int'(resume_start === 1'b1);
		n_cpurst <= n_cpurst + int'(cpu_reset === 1'b1);
	end
	// k: 0 bus reset, 1 start of frame, 2 bus stays idle from now on
	task automatic ev(input int k, input logic crc);
		@(posedge clk);
		bus_reset   <= (k == 0);
		sof_rx      <= (k == 1);
		sof_crc_err <= crc;
		bus_idle    <= bus_idle | (k == 2);
		@(posedge clk);
		{bus_reset, sof_rx, sof_crc_err} <= 3'b000;
	endtask : ev
	task automatic out_pkt(input int n, input logic crc, input logic [7:0] s,
			output logic [1:0] an);
		@(posedge clk);
		rx_start <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			{rx_start, rx_valid} <= 2'b01;
			rx_byte <= 8'(s + i);
		end
		@(posedge clk);
		{rx_start, rx_valid, rx_end, rx_crc_err} <= {3'b001, crc};
		// A released data line must not keep showing the last byte
		rx_byte <= ~rx_byte;
		@(posedge clk);
		{rx_end, rx_crc_err} <= 2'b00;
		@(negedge clk);
		an = {out_ack, tx_nak};
	endtask : out_pkt
	task automatic in_tok(output logic nak);
		logic fin;
		got = {};
		nak = 1'b0;
		fin = 1'b0;
		@(posedge clk);
		in_token <= 1'b1;
		@(posedge clk);
		in_token <= 1'b0;
		for (int i = 0; i < 80 && !fin; i++) begin
			@(negedge clk);
			if (tx_valid === 1'b1) got.push_back(tx_byte);
			nak = (tx_nak === 1'b1);
			fin = nak || (tx_last === 1'b1);
		end
	endtask : in_tok
endmodule : uebc_host

// *** verif/testbench.sv ***
// Self-checking bench for the endpoint bank controller
`timescale 1ns/1ns
module testbench;
	localparam int IDLE = 20;
	localparam int BANK = 64;
	logic        clk, srst, psel, penable, pwrite, usb_enable, err, nak;
	logic        pready, pslverr, tx_valid, tx_last, out_ack, tx_nak, resume_start;
	logic        cpu_reset, pullup_en, endpoint_irq, device_irq, bus_idle, bus_reset;
	logic        sof_rx, sof_crc_err, in_token, rx_start, rx_valid, rx_end;
	logic        rx_crc_err, resume_done;
	logic [7:0]  tx_byte, rx_byte, s, s2;
	logic [31:0] paddr, pwdata, prdata, r;
	logic [1:0]  an;
	int          num_errors = 0;
	int          n_tests    = 0;
	int          n, n2;
	uebc_top #(.BANK_BYTES(BANK), .IDLE_CYCLES(IDLE)) u_uebc_top (
		.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .usb_enable, .bus_idle, .bus_reset, .sof_rx, .sof_crc_err,
		.in_token, .rx_start, .rx_valid, .rx_byte, .rx_end, .rx_crc_err,
		.resume_done, .tx_valid, .tx_byte, .tx_last, .out_ack, .tx_nak,
		.resume_start, .cpu_reset, .pullup_en, .endpoint_irq, .device_irq);
	uebc_host u_uebc_host (
		.clk, .tx_valid, .tx_byte, .tx_last, .out_ack, .tx_nak, .resume_start,
		.cpu_reset, .bus_idle, .bus_reset, .sof_rx, .sof_crc_err, .in_token,
		.rx_start, .rx_valid, .rx_byte, .rx_end, .rx_crc_err, .resume_done);
	always #2 clk = ~clk;
	function automatic logic [31:0] xb(input logic [7:0] b, input int i);
		return {24'h000000, 8'(b + i)};
	endfunction : xb
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
		n_tests++;
		if (seen !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, seen);
		end
	endtask : check
	task automatic stop_test;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		{psel, penable, pwrite} <= {2'b10, w};
		paddr  <= {24'h000000, a};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		// Read data and the write both belong to the edge that sees pready high
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			stop_test();
		end
		r   = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check($sformatf("reg_%h", a), r & m, e);
	endtask : rdchk
	task automatic epf(input logic [31:0] m, input logic [31:0] e);
		rdchk(uebc_pkg::A_EP_FLAGS, m, e);
	endtask : epf
	// Ready flag is cleared first, then the bank is handed over
	task automatic rel;
		apb(1'b1, uebc_pkg::A_EP_FLAGS, 32'h100);
		apb(1'b1, uebc_pkg::A_EP_FLAGS, 32'h0);
	endtask : rel
	task automatic do_reset(input logic [31:0] cfg);
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		apb(1'b1, uebc_pkg::A_EP_CFG, cfg);
	endtask : do_reset
	initial begin
		{clk, srst, psel, penable, pwrite, usb_enable} = 6'b010001;
		{paddr, pwdata} = '0;
		void'($urandom(39));
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rdchk(uebc_pkg::A_DEV_CTRL, 32'hFF, 32'h01);
		@(negedge clk);
		check("pullup_en", pullup_en, 32'h0);
		apb(1'b1, uebc_pkg::A_DEV_CTRL, 32'h2);
		repeat (8) @(posedge clk);
		check("resume_start", u_uebc_host.n_resume, 32'h1);
		rdchk(uebc_pkg::A_DEV_CTRL, 32'hFF, 32'h00);
		rdchk(uebc_pkg::A_DEV_FLAGS, 32'hFF, 32'h40);
		@(negedge clk);
		check("pullup_en", pullup_en, 32'h1);
		check("device_irq", device_irq, 32'h0);
		apb(1'b1, uebc_pkg::A_DEV_EN, 32'h40);
		@(negedge clk);
		check("device_irq", device_irq, 32'h1);
		apb(1'b1, uebc_pkg::A_DEV_FLAGS, 32'hFF);
		rdchk(uebc_pkg::A_DEV_FLAGS, 32'hFF, 32'h40);
		apb(1'b1, uebc_pkg::A_DEV_FLAGS, 32'h0);
		u_uebc_host.ev(2, 1'b0);
		repeat (IDLE - 8) @(posedge clk);
		rdchk(uebc_pkg::A_DEV_FLAGS, 32'hFF, 32'h00);
		repeat (8) @(posedge clk);
		rdchk(uebc_pkg::A_DEV_FLAGS, 32'hFF, 32'h01);
		u_uebc_host.ev(1, 1'b1);
		rdchk(uebc_pkg::A_DEV_FLAGS, 32'hFF, 32'h05);
		rdchk(uebc_pkg::A_FRAME_ERR, 32'hFF, 32'h10);
		apb(1'b1, uebc_pkg::A_DEV_CTRL, 32'h4);
		u_uebc_host.ev(0, 1'b0);
		repeat (4) @(posedge clk);
		check("cpu_reset", u_uebc_host.n_cpurst, 32'h1);
		usb_enable <= 1'b0;
		@(posedge clk);
		usb_enable <= 1'b1;
		rdchk(uebc_pkg::A_DEV_CTRL, 32'hFF, 32'h00);
		u_uebc_host.ev(0, 1'b0);
		repeat (4) @(posedge clk);
		check("cpu_reset", u_uebc_host.n_cpurst, 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped", {r[30:0], err}, 32'h1);
		// Single OUT bank: second packet meets a busy bank
		do_reset(32'h0);
		apb(1'b1, uebc_pkg::A_EP_EN, 32'h04);
		n = 1 + $urandom % BANK;
		s = 8'($urandom);
		u_uebc_host.out_pkt(n, 1'b0, s, an);
		check("out_ack", an, 32'h2);
		epf(32'h184, 32'h184);
		@(negedge clk);
		check("endpoint_irq", endpoint_irq, 32'h1);
		rdchk(uebc_pkg::A_EP_COUNT, 32'hFF, n);
		u_uebc_host.out_pkt(4, 1'b0, s, an);
		check("out_nak", an, 32'h1);
		epf(32'h8, 32'h8);
		apb(1'b1, uebc_pkg::A_EP_FLAGS, 32'h100);
		for (int i = 0; i < n; i++) rdchk(uebc_pkg::A_EP_DATA, 32'hFF, xb(s, i));
		epf(32'h180, 32'h100);
		apb(1'b1, uebc_pkg::A_EP_FLAGS, 32'h0);
		epf(32'h184, 32'h0);
		// Two OUT banks, then an oversized packet
		do_reset(32'h2);
		n2 = 1 + $urandom % BANK;
		s2 = 8'($urandom);
		u_uebc_host.out_pkt(n, 1'b0, s, an);
		u_uebc_host.out_pkt(n2, 1'b0, s2, an);
		check("out_ack", an, 32'h2);
		rdchk(uebc_pkg::A_EP_COUNT, 32'hFF, n);
		rel();
		epf(32'h184, 32'h184);
		rdchk(uebc_pkg::A_EP_COUNT, 32'hFF, n2);
		rdchk(uebc_pkg::A_EP_DATA, 32'hFF, xb(s2, 0));
		rel();
		u_uebc_host.out_pkt(BANK + 2, 1'b0, s, an);
		check("out_ack", an, 32'h2);
		epf(32'h24, 32'h24);
		rdchk(uebc_pkg::A_EP_COUNT, 32'hFF, BANK);
		rdchk(uebc_pkg::A_EP_DATA, 32'hFF, xb(s, 0));
		do_reset(32'h4);
		u_uebc_host.out_pkt(5, 1'b1, s, an);
		epf(32'h6, 32'h6);
		u_uebc_host.out_pkt(7, 1'b0, s2, an);
		check("iso_drop", an, 32'h0);
		rdchk(uebc_pkg::A_EP_COUNT, 32'hFF, 32'h5);
		// IN bank: fill, send, then NAK and kill
		do_reset(32'h1);
		apb(1'b1, uebc_pkg::A_EP_EN, 32'h01);
		epf(32'h181, 32'h181);
		@(negedge clk);
		check("endpoint_irq", endpoint_irq, 32'h1);
		for (int i = 0; i < n; i++) apb(1'b1, uebc_pkg::A_EP_DATA, xb(s, i));
		rel();
		u_uebc_host.in_tok(nak);
		check("tx_len", u_uebc_host.got.size(), n);
		for (int i = 0; i < n; i++) check("tx_byte", u_uebc_host.got[i], xb(s, i));
		epf(32'h101, 32'h101);
		u_uebc_host.in_tok(nak);
		check("in_nak", nak, 32'h1);
		epf(32'h10, 32'h10);
		apb(1'b1, uebc_pkg::A_EP_DATA, 32'h5A);
		rel();
		apb(1'b1, uebc_pkg::A_EP_FLAGS, 32'h300);
		u_uebc_host.in_tok(nak);
		check("killed", nak, 32'h1);
		do_reset(32'h3);
		for (int i = 0; i < BANK; i++) apb(1'b1, uebc_pkg::A_EP_DATA, xb(s2, i));
		epf(32'h80, 32'h0);
		rel();
		epf(32'h181, 32'h181);
		do_reset(32'h5);
		u_uebc_host.in_tok(nak);
		epf(32'h40, 32'h40);
		stop_test();
	end
endmodule : testbench
